//--- i2c_indexed_register_slave.sv
// serial register slave holding 256 8-bit registers
// assumes scl and sda arrive asynchronous; sda wire formed outside
module i2c_indexed_register_slave
  import i2c_slave_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            scl_out,
  output logic            scl_oe,
  output logic [7:0]      ptr_value,
  output logic            busy,
  output logic            store_stall
);
  `include "i2c_slave_map.svh"
  import i2c_slave_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;

  i2c_sync u_scl_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin     (scl_in),
    .level   (scl_s)
  );

  i2c_sync u_sda_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin     (sda_in),
    .level   (sda_s)
  );

  // ==========================================================
  // edge and condition detection
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // delayed copies for edge finding
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_d;
  assign scl_fall   = !scl_s && scl_d;
  // sda moving while scl high is a condition, never data
  assign start_cond = scl_s && scl_d && sda_d && !sda_s;
  assign stop_cond  = scl_s && scl_d && !sda_d && sda_s;

  // ==========================================================
  // register storage and protocol state
  logic [7:0]  regs [`REG_COUNT];
  link_state_t state;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift;
  logic        dir_read;
  logic        ptr_loaded;
  logic [7:0]  ptr;
  logic        sda_low;
  logic        master_ack_bit;

  // fifo carries pointer and byte to the storing side
  logic        wf_in_valid;
  logic        wf_in_ready;
  logic [15:0] wf_in_data;
  logic        wf_out_valid;
  logic [15:0] wf_out_data;

  i2c_fifo #(
    .WIDTH (`WFIFO_WIDTH),
    .DEPTH (`WFIFO_DEPTH)
  ) u_wfifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (wf_in_valid),
    .in_ready  (wf_in_ready),
    .in_data   (wf_in_data),
    .out_valid (wf_out_valid),
    .out_ready (1'b1),
    .out_data  (wf_out_data)
  );

  // a full fifo refuses data bytes, so the master stops streaming;
  // the pointer byte needs no fifo room and is always taken
  logic byte_done;
  logic slave_ack_bit;
  logic slot_on;
  logic in_slot;
  logic slot_open;
  logic slot_end;
  assign byte_done     = scl_rise && (bit_cnt == `BIT_LAST);
  assign slave_ack_bit = !ptr_loaded || wf_in_ready;
  // an acknowledge slot spans two falling clocks: open, then close
  assign in_slot   = (state == ST_AACK) || (state == ST_WACK)
                     || (state == ST_RACK);
  assign slot_open = in_slot && scl_fall && !slot_on;
  assign slot_end  = in_slot && scl_fall && slot_on;

  // queue a data byte as its acknowledge slot closes
  assign wf_in_valid = (state == ST_WACK) && slot_end && ptr_loaded
                       && sda_low;
  assign wf_in_data  = {ptr, shift};

  // ==========================================================
  // protocol state machine
  // byte states count eight rising clocks; slot states wait for
  // their second falling clock before handing the line over
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else if (start_cond) begin
      state <= ST_ADDR;
    end else if (stop_cond) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_ADDR: begin
          if (byte_done) begin
            // own address gets an ack slot, others are ignored
            if (shift[6:0] == `DEV_ADDR_7) begin
              state <= ST_AACK;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          // a read byte is loaded as this slot closes
          if (slot_end) begin
            state <= dir_read ? ST_RBYTE : ST_WBYTE;
          end
        end
        ST_WBYTE: begin
          if (byte_done) begin
            state <= ST_WACK;
          end
        end
        ST_WACK: begin
          // a refused byte ends the stream until the next start
          if (slot_end) begin
            state <= sda_low ? ST_WBYTE : ST_SKIP;
          end
        end
        ST_RBYTE: begin
          if (byte_done) begin
            state <= ST_RACK;
          end
        end
        ST_RACK: begin
          // master nack ends the read and frees the line
          if (slot_end) begin
            state <= master_ack_bit ? ST_RBYTE : ST_SKIP;
          end
        end
        ST_SKIP: begin
          state <= ST_SKIP;
        end
      endcase
    end
  end

  // ==========================================================
  // bit counter: eight rising clocks make a byte, then it wraps
  // to zero, so every byte state starts from a clean count
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_cnt <= 3'h0;
    end else if (start_cond || stop_cond) begin
      bit_cnt <= 3'h0;
    end else if (scl_rise && (state == ST_ADDR || state == ST_WBYTE
                              || state == ST_RBYTE)) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // slot flag tells the opening fall from the closing one;
  // a start or stop inside a slot drops it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slot_on <= 1'b0;
    end else if (start_cond || stop_cond) begin
      slot_on <= 1'b0;
    end else if (slot_open) begin
      slot_on <= 1'b1;
    end else if (slot_end) begin
      slot_on <= 1'b0;
    end
  end

  // receive shifter samples sda on the rising clock, msb first;
  // read bytes are parallel loaded when the slot before them closes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shift <= 8'h00;
    end else if (scl_rise && (state == ST_ADDR || state == ST_WBYTE)) begin
      shift <= {shift[6:0], sda_s};
    end else if (slot_end && (state == ST_AACK || state == ST_RACK)) begin
      shift <= regs[ptr];
    end else if (state == ST_RBYTE && scl_fall) begin
      shift <= {shift[6:0], 1'b1};
    end
  end

  // direction bit latched with every address byte, matching or not
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dir_read <= 1'b0;
    end else if (state == ST_ADDR && byte_done) begin
      dir_read <= sda_s;
    end
  end

  // master acknowledge sampled on the rising clock of its slot
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      master_ack_bit <= 1'b0;
    end else if (state == ST_RACK && scl_rise) begin
      master_ack_bit <= !sda_s;
    end
  end

  // ==========================================================
  // register pointer: first write byte loads, data bytes step it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ptr        <= `PTR_RESET;
      ptr_loaded <= 1'b0;
    end else if (start_cond) begin
      ptr_loaded <= 1'b0;
    end else if (state == ST_WACK && slot_end && sda_low) begin
      if (!ptr_loaded) begin
        ptr        <= shift;
        ptr_loaded <= 1'b1;
      end else begin
        ptr <= ptr + 8'h01;
      end
    end else if (state == ST_RACK && scl_rise) begin
      ptr <= ptr + 8'h01;
    end
  end

  // storing side drains the fifo into the register array
  always_ff @(posedge sys_clk) begin
    if (wf_out_valid) begin
      regs[wf_out_data[15:8]] <= wf_out_data[7:0];
    end
  end

  // ==========================================================
  // data line pull-down, changed only just after a falling clock,
  // so the master never sees it move while the clock is high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sda_low <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_low <= 1'b0;
    end else if (scl_fall) begin
      unique case (state)
        ST_AACK: begin
          if (slot_on) begin
            // closing slot: a read puts its first msb out now
            sda_low <= dir_read && !regs[ptr][7];
          end else begin
            sda_low <= 1'b1;
          end
        end
        ST_WACK: begin
          // pointer bytes are always taken, data needs fifo room
          if (slot_on) begin
            sda_low <= 1'b0;
          end else begin
            sda_low <= slave_ack_bit;
          end
        end
        ST_RBYTE: begin
          sda_low <= !shift[6];
        end
        ST_RACK: begin
          // line is freed for the master's slot, then the next byte
          if (slot_on) begin
            sda_low <= master_ack_bit && !regs[ptr][7];
          end else begin
            sda_low <= 1'b0;
          end
        end
        ST_IDLE, ST_ADDR, ST_WBYTE, ST_SKIP: begin
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // pins and status
  assign sda_out     = 1'b0;
  assign sda_oe      = sda_low;
  assign scl_out     = 1'b0;
  assign scl_oe      = 1'b0;
  assign ptr_value   = ptr;
  assign busy        = (state != ST_IDLE);
  assign store_stall = !wf_in_ready;
endmodule

//--- i2c_slave_map.svh
// register-pointer serial slave: timing and address constants
// assumes inclusion by the register slave module only
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

// 7-bit bus address; write byte 0x52, read byte 0x53
`define DEV_ADDR_7        7'h29
// register space: 256 locations of 8 bits
`define REG_COUNT         256
`define PTR_RESET         8'h00
`define REG_RESET         8'h00
// link rate ceiling kept by the master, in kbit/s
`define LINK_MAX_KBPS     400
// fifo between byte capture and register store
`define WFIFO_DEPTH       4
`define WFIFO_WIDTH       16
// byte bit counter
`define BIT_LAST          3'h7

`endif

//--- i2c_slave_pkg.sv
// types shared by the serial slave modules
// assumes i2c_slave_map.svh sits in the include path
package i2c_slave_pkg;
  // ==========================================================
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WBYTE = 3'b011,
    ST_WACK  = 3'b100,
    ST_RBYTE = 3'b101,
    ST_RACK  = 3'b110,
    ST_SKIP  = 3'b111
  } link_state_t;
endpackage

//--- i2c_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk
module i2c_sync (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic meta;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta  <= 1'b1;
      level <= 1'b1;
    end else begin
      meta  <= pin;
      level <= meta;
    end
  end
endmodule

//--- i2c_fifo.sv
// small valid/ready fifo, width and depth as parameters
// assumes one clock and synchronous active-low reset
module i2c_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- i2c_indexed_register_slave_checker.sv
// checker for the register slave pins, bound into the slave top
// assumes raw pin levels; the slave answers a few sys_clk later
module i2c_slave_checker (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic [7:0] ptr_value,
  input wire logic       busy,
  input wire logic       store_stall
);
  // ==========================================================
  // pin relations
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_no_scl; !scl_oe; endproperty
  a_no_scl: assert property (p_no_scl) else $error("clock driven");
  property p_low_only; sda_oe |-> !sda_out; endproperty
  a_low_only: assert property (p_low_only) else $error("sda high");
  property p_idle_free; !busy |-> !sda_oe; endproperty
  a_idle_free: assert property (p_idle_free) else $error("idle pull");
  // data must not move while the clock pin is high
  property p_hold_high; scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("moved");
  property p_start_seen;
    $fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] busy;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start");
  property p_stop_seen;
    $rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] !busy;
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("stop");
  property p_ptr_quiet; !busy && !$past(busy) |-> $stable(ptr_value);
  endproperty
  a_ptr_quiet: assert property (p_ptr_quiet) else $error("ptr");
  // pulls start only in the clock-low phase, after sync delay
  property p_drive_phase; $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_drive_phase: assert property (p_drive_phase) else $error("edge");

  c_start: cover property ($fell(sda_in) && scl_in);
  c_pull: cover property ($rose(sda_oe));
  c_ptr: cover property (busy && $changed(ptr_value));
endmodule

bind i2c_indexed_register_slave i2c_slave_checker u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
  .scl_oe(scl_oe), .ptr_value(ptr_value), .busy(busy),
  .store_stall(store_stall)
);

//--- i2c_host_model.sv
// host bus master model: pulls scl and sda low or lets them go
// assumes the bench forms both wired lines with pull-ups
module i2c_host_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter bit of 25 cycles: 2.5 us bits, exactly at the rate cap
  localparam int Q = 25;

  // ==========================================================
  // line conditions; only this side makes the clock
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic q();
    repeat (Q) @(posedge sys_clk);
  endtask
  // works from idle and as repeated start
  task automatic start();
    sda_pull <= 1'b0;
    q();
    scl_pull <= 1'b0;
    q();
    sda_pull <= 1'b1;
    q();
    scl_pull <= 1'b1;
    q();
  endtask
  // leaves both lines released for idle
  task automatic stop();
    sda_pull <= 1'b1;
    q();
    scl_pull <= 1'b0;
    q();
    sda_pull <= 1'b0;
    q();
  endtask
  // one clock pulse; data set while low, sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    sda_pull <= !b;
    q();
    scl_pull <= 1'b0;
    q();
    r = sda;
    q();
    scl_pull <= 1'b1;
    q();
  endtask
  // eight bits msb first then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
    clk_bit(ack_in, a);
    ack = !a;
  endtask
endmodule

//--- test_i2c_indexed_register_slave.sv
// self-checking bench for the register slave with a host model
// assumes the checker is bound in through its own file
module test_i2c_indexed_register_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk;
  logic       rstn;
  logic       sda_out;
  logic       sda_oe;
  logic       scl_out;
  logic       scl_oe;
  logic       busy;
  logic       store_stall;
  logic       scl_pull;
  logic       sda_pull;
  logic [7:0] ptr_value;
  int         errors;
  int         n_tests;
  int         cyc;
  // wired lines with pull-ups: any pulling party wins
  wire logic  scl = ~scl_pull & ~(scl_oe & ~scl_out);
  wire logic  sda = ~sda_pull & ~(sda_oe & ~sda_out);

  i2c_indexed_register_slave u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
    .scl_oe(scl_oe), .ptr_value(ptr_value), .busy(busy),
    .store_stall(store_stall));
  i2c_host_model u_host (
    .sys_clk(sys_clk), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull));

  // ==========================================================
  // clock, hang guard and helpers
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ceiling well above the roughly 30 bytes of traffic
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      test_done();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    u_host.xfer(d, 1'b1, r, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic rd(input logic [7:0] exp, input logic m_ack);
    logic [7:0] r;
    logic       a;
    u_host.xfer(8'hFF, !m_ack, r, a);
    check(r, exp);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check({4'h0, store_stall, sda_oe, scl_oe, busy}, 8'h00);
    check(ptr_value, 8'h00);
  endtask
  // foreign address: no ack, later bytes ignored
  task automatic t_foreign();
    u_host.start();
    wr(8'h54, 1'b0);
    wr(8'h33, 1'b0);
    u_host.stop();
    check(ptr_value, 8'h00);
  endtask
  // sequential write across the pointer wrap
  task automatic t_write();
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'hFE, 1'b1);
    check(ptr_value, 8'hFE);
    wr(8'hA1, 1'b1);
    wr(8'hB2, 1'b1);
    wr(8'hC3, 1'b1);
    u_host.stop();
    check(ptr_value, 8'h01);
  endtask
  // pointer-only write, then a separate read ended by a nack
  task automatic t_read();
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'hFE, 1'b1);
    u_host.stop();
    u_host.start();
    wr(8'h53, 1'b1);
    rd(8'hA1, 1'b1);
    rd(8'hB2, 1'b1);
    rd(8'hC3, 1'b0);
    check({7'h00, sda_oe}, 8'h00);
    u_host.stop();
    check(ptr_value, 8'h01);
  endtask
  // repeated starts with no stop between messages
  task automatic t_restart();
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'h6B, 1'b1);
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'h10, 1'b1);
    u_host.start();
    wr(8'h53, 1'b1);
    rd(8'h5A, 1'b1);
    rd(8'h6B, 1'b0);
    u_host.stop();
  endtask
  // stop after half a data byte must not store it
  task automatic t_abort();
    logic r;
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'h20, 1'b1);
    wr(8'h77, 1'b1);
    u_host.stop();
    u_host.start();
    wr(8'h52, 1'b1);
    wr(8'h20, 1'b1);
    for (int i = 0; i < 4; i++) u_host.clk_bit(1'b0, r);
    u_host.stop();
    check(ptr_value, 8'h20);
    u_host.start();
    wr(8'h53, 1'b1);
    rd(8'h77, 1'b0);
    u_host.stop();
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_foreign();
    t_write();
    t_read();
    t_restart();
    t_abort();
    test_done();
  end
endmodule
